// ---- design/flash_status_pkg.sv ----
// Constants, command codes and field layout of the status register bank
// Overview of operation
// - Busy flag S0 rises while program, erase, status write or security op runs.
// - While busy, only status reads and suspend are obeyed.
// - Busy clears when the running operation reports completion.
// - Write enable latch S1 sets after a write enable command.
// - Latch clears at power-up, write disable and every program, erase or status write.
// - Block protect field S5..S2 is read/write through status write.
// - Block protect field resets to zero: nothing protected.
// - Top/bottom select picks top (0) or bottom (1); default 0.
// - Top/bottom select changes only when lock and enable latch allow.
// - Complement protect S14, default 0, inverts the protected region.
// - Status lock S8 at 1 refuses status writes until power cycle.
// - Paused flag S15 sets on suspend, clears on resume or power cycle.
// - Security lock bits S13..S11 default 0, settable once, cleared only by power-on reset.
// - Active address width reads 0 in three-byte mode, 1 in four-byte.
// - Boot address width used at init and soft reset, written by enabled status write.
// - Boot width 0 starts three-byte mode; 1 starts four-byte mode.
// - Scheme select 0 uses protect fields, 1 uses individual block locks.
// - All individual block locks are set at power-on and every reset.
// - Output strength 00 full, 01 3/4, 10 half, 11 quarter; default 11.
// - Reserved bits ignore writes and read as zero.
// - Status writes need status lock clear and write enable latch set.
package flash_status_pkg;

    typedef enum logic [3:0] {
        CMD_NONE      = 4'b0000,
        CMD_WREN      = 4'b0001,
        CMD_WRDI      = 4'b0010,
        CMD_RDSR      = 4'b0011,
        CMD_WRSR      = 4'b0100,
        CMD_PROG      = 4'b0101,
        CMD_QPROG     = 4'b0110,
        CMD_ERASE     = 4'b0111,
        CMD_SEC_PROG  = 4'b1000,
        CMD_SEC_ERASE = 4'b1001,
        CMD_SUSPEND   = 4'b1010,
        CMD_RESUME    = 4'b1011,
        CMD_EN4B      = 4'b1100,
        CMD_EX4B      = 4'b1101,
        CMD_SOFT_RST  = 4'b1110
    } cmd_t;

    typedef enum logic [1:0] {
        SEL_ONE   = 2'b00,
        SEL_TWO   = 2'b01,
        SEL_THREE = 2'b10
    } reg_sel_t;

    // Byte one layout
    localparam int BIT_BUSY    = 0;
    localparam int BIT_WEL     = 1;
    localparam int BP_LSB      = 2;
    localparam int BP_MSB      = 5;
    localparam int BIT_TB      = 6;
    // Byte two layout (bit within the byte)
    localparam int BIT_SRL     = 0;
    localparam int LB_LSB      = 3;
    localparam int LB_MSB      = 5;
    localparam int BIT_CMP     = 6;
    localparam int BIT_SUS     = 7;
    // Byte three layout
    localparam int BIT_ADS     = 0;
    localparam int BIT_ADP     = 1;
    localparam int BIT_WPS     = 2;
    localparam int DRV_LSB     = 5;
    localparam int DRV_MSB     = 6;

    localparam int BYTE_W      = 8;
    localparam int BP_W        = 4;
    localparam int LB_W        = 3;
    localparam int DRV_W       = 2;

    localparam logic [BP_W-1:0]  BP_RESET  = 4'h0;
    localparam logic [LB_W-1:0]  LB_RESET  = 3'h0;
    localparam logic [DRV_W-1:0] DRV_RESET = 2'h3;
    localparam logic             TB_RESET  = 1'b0;
    localparam logic             CMP_RESET = 1'b0;
    localparam logic             WPS_RESET = 1'b0;
    localparam logic             ADP_RESET = 1'b0;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0]        BIT_CNT_LAST = 3'h7;

endpackage

// ---- design/status_reset_sync.sv ----
// Two-stage release synchroniser for the active-low reset
module status_reset_sync (
    input  wire logic i_clk,    // System clock
    input  wire logic i_rst_n,  // Asynchronous reset, active low
    output logic      o_rst_n   // Synchronised reset, active low
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            sync_q <= meta_q;
        end
    end

    assign o_rst_n = sync_q;
endmodule

// ---- design/status_byte_shifter.sv ----
// Loads one status byte and shifts it out most significant bit first
module status_byte_shifter
    import flash_status_pkg::*;
(
    input  wire logic                             i_clk,     // System clock
    input  wire logic                             i_rst_n,   // Synchronised reset, active low
    input  wire logic                             i_load,    // Load pulse
    input  wire logic [flash_status_pkg::BYTE_W-1:0] i_byte, // Byte to send
    input  wire logic                             i_shift,   // Advance one bit
    output logic                                  o_sdo,     // Serial data bit
    output logic                                  o_active   // Byte in flight
);
    logic [BYTE_W-1:0] sh_q, sh_d;
    logic [2:0]        cnt_q, cnt_d;
    logic              act_q, act_d;

    always_comb begin
        sh_d  = sh_q;
        cnt_d = cnt_q;
        act_d = act_q;
        if (i_load) begin
            sh_d  = i_byte;
            cnt_d = 3'h0;
            act_d = 1'b1;
        end else if (i_shift && act_q) begin
            sh_d = {sh_q[BYTE_W-2:0], 1'b0};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == BIT_CNT_LAST) begin
                act_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sh_q  <= BYTE_ZERO;
            cnt_q <= 3'h0;
            act_q <= 1'b0;
        end else begin
            sh_q  <= sh_d;
            cnt_q <= cnt_d;
            act_q <= act_d;
        end
    end

    assign o_sdo    = sh_q[BYTE_W-1];
    assign o_active = act_q;
endmodule

// ---- design/serial_flash_status_regs.sv ----
// Status and configuration register bank of one flash die
module serial_flash_status_regs
    import flash_status_pkg::*;
(
    input  wire logic                                i_clk,        // 50 MHz clock
    input  wire logic                                i_rst_n,      // Power-on reset, active low
    input  wire logic                                i_cmd_valid,  // Decoded command strobe
    input  wire flash_status_pkg::cmd_t              i_cmd,        // Decoded command
    input  wire flash_status_pkg::reg_sel_t          i_reg_sel,    // Status byte selected
    input  wire logic [flash_status_pkg::BYTE_W-1:0] i_wr_data,    // Status write byte
    input  wire logic                                i_op_done,    // Engine finished pulse
    input  wire logic                                i_shift,      // Serial bit enable
    output logic                                     o_cmd_taken,  // Command accepted pulse
    output logic                                     o_cmd_ignored,// Command dropped pulse
    output logic                                     o_op_start,   // Start engine pulse
    output logic                                     o_lock_preset,// Set all block locks pulse
    output logic [flash_status_pkg::BYTE_W-1:0]      o_rd_data,    // Last byte read
    output logic                                     o_sdo,        // Serial status bit
    output logic                                     o_sdo_active, // Byte being shifted
    output logic                                     o_busy,       // Operation running
    output logic                                     o_wel,        // Write enable latch
    output logic [flash_status_pkg::BP_W-1:0]        o_bp,         // Block protect field
    output logic                                     o_tb,         // Top/bottom select
    output logic                                     o_cmp,        // Complement protect
    output logic                                     o_srl,        // Status lock
    output logic                                     o_sus,        // Paused op flag
    output logic [flash_status_pkg::LB_W-1:0]        o_sec_lock,   // Security lock bits
    output logic                                     o_ads,        // Four-byte mode active
    output logic                                     o_adp,        // Boot in four-byte mode
    output logic                                     o_wps,        // Block-lock scheme
    output logic [flash_status_pkg::DRV_W-1:0]       o_drv         // Output strength code
);
    import flash_status_pkg::*;

    logic rst_n;

    status_reset_sync u_rst (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .o_rst_n (rst_n)
    );

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic              busy_q, busy_d;
    logic              wel_q, wel_d;
    logic [BP_W-1:0]   bp_q, bp_d;
    logic              tb_q, tb_d;
    logic              cmp_q, cmp_d;
    logic              srl_q, srl_d;
    logic              sus_q, sus_d;
    logic [LB_W-1:0]   lb_q, lb_d;
    logic              ads_q, ads_d;
    logic              adp_q, adp_d;
    logic              wps_q, wps_d;
    logic [DRV_W-1:0]  drv_q, drv_d;
    logic [BYTE_W-1:0] rd_q, rd_d;
    logic              taken_q, taken_d;
    logic              ign_q, ign_d;
    logic              start_q, start_d;
    logic              preset_q, preset_d;
    logic              first_q;

    logic [BYTE_W-1:0] byte_one;
    logic [BYTE_W-1:0] byte_two;
    logic [BYTE_W-1:0] byte_three;
    logic [BYTE_W-1:0] sel_byte;
    logic              rd_load;
    logic              wr_ok;
    logic              allowed;

    // Reserved bits read as zero
    always_comb begin
        byte_one                 = BYTE_ZERO;
        byte_one[BIT_BUSY]       = busy_q;
        byte_one[BIT_WEL]        = wel_q;
        byte_one[BP_MSB:BP_LSB]  = bp_q;
        byte_one[BIT_TB]         = tb_q;
        byte_two                 = BYTE_ZERO;
        byte_two[BIT_SRL]        = srl_q;
        byte_two[LB_MSB:LB_LSB]  = lb_q;
        byte_two[BIT_CMP]        = cmp_q;
        byte_two[BIT_SUS]        = sus_q;
        byte_three               = BYTE_ZERO;
        byte_three[BIT_ADS]      = ads_q;
        byte_three[BIT_ADP]      = adp_q;
        byte_three[BIT_WPS]      = wps_q;
        byte_three[DRV_MSB:DRV_LSB] = drv_q;
        case (i_reg_sel)
            SEL_ONE:   sel_byte = byte_one;
            SEL_TWO:   sel_byte = byte_two;
            SEL_THREE: sel_byte = byte_three;
            default:   sel_byte = BYTE_ZERO;
        endcase
    end

    assign wr_ok = wel_q && !srl_q;

    // While busy only reads and suspend get through
    always_comb begin
        if (!i_cmd_valid) begin
            allowed = 1'b0;
        end else if (busy_q) begin
            allowed = (i_cmd == CMD_RDSR) || (i_cmd == CMD_SUSPEND);
        end else begin
            case (i_cmd)
                CMD_NONE:      allowed = 1'b0;
                CMD_WRSR:      allowed = wr_ok;
                CMD_PROG,
                CMD_QPROG,
                CMD_ERASE,
                CMD_SEC_PROG,
                CMD_SEC_ERASE: allowed = wel_q;
                CMD_SUSPEND:   allowed = 1'b0;
                CMD_RESUME:    allowed = sus_q;
                default:       allowed = 1'b1;
            endcase
        end
    end

    assign rd_load = allowed && (i_cmd == CMD_RDSR);

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        busy_d   = busy_q;
        wel_d    = wel_q;
        bp_d     = bp_q;
        tb_d     = tb_q;
        cmp_d    = cmp_q;
        srl_d    = srl_q;
        sus_d    = sus_q;
        lb_d     = lb_q;
        ads_d    = ads_q;
        adp_d    = adp_q;
        wps_d    = wps_q;
        drv_d    = drv_q;
        rd_d     = rd_load ? sel_byte : rd_q;
        taken_d  = allowed;
        ign_d    = i_cmd_valid && (i_cmd != CMD_NONE) && !allowed;
        start_d  = 1'b0;
        preset_d = first_q;
        if (busy_q && i_op_done) begin
            busy_d = 1'b0;
        end
        if (allowed) begin
            case (i_cmd)
                CMD_WREN: wel_d = 1'b1;
                CMD_WRDI: wel_d = 1'b0;
                CMD_PROG,
                CMD_QPROG,
                CMD_ERASE,
                CMD_SEC_PROG,
                CMD_SEC_ERASE: begin
                    busy_d  = 1'b1;
                    wel_d   = 1'b0;
                    start_d = 1'b1;
                end
                CMD_WRSR: begin
                    busy_d  = 1'b1;
                    wel_d   = 1'b0;
                    start_d = 1'b1;
                    case (i_reg_sel)
                        SEL_ONE: begin
                            bp_d = i_wr_data[BP_MSB:BP_LSB];
                            tb_d = i_wr_data[BIT_TB];
                        end
                        SEL_TWO: begin
                            srl_d = i_wr_data[BIT_SRL];
                            lb_d  = lb_q | i_wr_data[LB_MSB:LB_LSB];
                            cmp_d = i_wr_data[BIT_CMP];
                        end
                        SEL_THREE: begin
                            adp_d = i_wr_data[BIT_ADP];
                            wps_d = i_wr_data[BIT_WPS];
                            drv_d = i_wr_data[DRV_MSB:DRV_LSB];
                        end
                        default: ;
                    endcase
                end
                CMD_SUSPEND: begin
                    // Suspended engine idles, so the bus is free again
                    sus_d  = 1'b1;
                    busy_d = 1'b0;
                end
                CMD_RESUME: begin
                    sus_d   = 1'b0;
                    busy_d  = 1'b1;
                    start_d = 1'b1;
                end
                CMD_EN4B: ads_d = 1'b1;
                CMD_EX4B: ads_d = 1'b0;
                CMD_SOFT_RST: begin
                    // Soft reset: busy, enable latch, paused flag and address mode back to power-on; status lock, security locks and NV bits kept
                    busy_d   = 1'b0;
                    wel_d    = 1'b0;
                    sus_d    = 1'b0;
                    ads_d    = adp_q;
                    preset_d = 1'b1;
                end
                default: ;
            endcase
        end
    end

    // Boot mode is taken from the stored bit once after release
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q   <= 1'b0;
            wel_q    <= 1'b0;
            bp_q     <= BP_RESET;
            tb_q     <= TB_RESET;
            cmp_q    <= CMP_RESET;
            srl_q    <= 1'b0;
            sus_q    <= 1'b0;
            lb_q     <= LB_RESET;
            ads_q    <= ADP_RESET;
            adp_q    <= ADP_RESET;
            wps_q    <= WPS_RESET;
            drv_q    <= DRV_RESET;
            rd_q     <= BYTE_ZERO;
            taken_q  <= 1'b0;
            ign_q    <= 1'b0;
            start_q  <= 1'b0;
            preset_q <= 1'b0;
        end else begin
            busy_q   <= busy_d;
            wel_q    <= wel_d;
            bp_q     <= bp_d;
            tb_q     <= tb_d;
            cmp_q    <= cmp_d;
            srl_q    <= srl_d;
            sus_q    <= sus_d;
            lb_q     <= lb_d;
            ads_q    <= first_q ? adp_q : ads_d;
            adp_q    <= adp_d;
            wps_q    <= wps_d;
            drv_q    <= drv_d;
            rd_q     <= rd_d;
            taken_q  <= taken_d;
            ign_q    <= ign_d;
            start_q  <= start_d;
            preset_q <= preset_d;
        end
    end

    // ****************************************************************
    // Serial read-out
    // ****************************************************************
    status_byte_shifter u_shift (
        .i_clk    (i_clk),
        .i_rst_n  (rst_n),
        .i_load   (rd_load),
        .i_byte   (sel_byte),
        .i_shift  (i_shift),
        .o_sdo    (o_sdo),
        .o_active (o_sdo_active)
    );

    assign o_cmd_taken   = taken_q;
    assign o_cmd_ignored = ign_q;
    assign o_op_start    = start_q;
    assign o_lock_preset = preset_q;
    assign o_rd_data     = rd_q;
    assign o_busy        = busy_q;
    assign o_wel         = wel_q;
    assign o_bp          = bp_q;
    assign o_tb          = tb_q;
    assign o_cmp         = cmp_q;
    assign o_srl         = srl_q;
    assign o_sus         = sus_q;
    assign o_sec_lock    = lb_q;
    assign o_ads         = ads_q;
    assign o_adp         = adp_q;
    assign o_wps         = wps_q;
    assign o_drv         = drv_q;
endmodule

// ---- verification/serial_flash_status_regs_props.sv ----
// Concurrent checks on the status register bank ports
module serial_flash_status_props
    import flash_status_pkg::*;
(
    input  wire logic                                i_clk,         // System clock
    input  wire logic                                i_rst_n,       // Reset, active low
    input  wire logic                                i_cmd_valid,   // Command strobe
    input  wire flash_status_pkg::cmd_t              i_cmd,         // Command
    input  wire logic                                i_op_done,     // Engine finished
    input  wire logic                                o_cmd_taken,   // Accepted pulse
    input  wire logic                                o_cmd_ignored, // Refused pulse
    input  wire logic                                o_op_start,    // Engine start
    input  wire logic [flash_status_pkg::BYTE_W-1:0] o_rd_data,     // Read byte
    input  wire logic                                o_sdo,         // Serial bit
    input  wire logic                                o_sdo_active,  // Byte in flight
    input  wire logic                                o_busy,        // Busy flag
    input  wire logic                                o_wel,         // Enable latch
    input  wire logic [flash_status_pkg::BP_W-1:0]   o_bp,          // Block protect
    input  wire logic                                o_tb,          // Top/bottom
    input  wire logic                                o_srl,         // Status lock
    input  wire logic                                o_sus,         // Paused flag
    input  wire logic [flash_status_pkg::LB_W-1:0]   o_sec_lock,    // Security locks
    input  wire logic                                o_ads,         // Address mode
    input  wire logic [flash_status_pkg::DRV_W-1:0]  o_drv          // Strength code
);
    // ************
    // Properties
    // ************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_rd_accept;
        i_cmd_valid && i_cmd == CMD_RDSR ##1 o_cmd_taken;
    endsequence
    sequence s_wrsr_ok;
        i_cmd_valid && i_cmd == CMD_WRSR && o_wel && !o_srl && !o_busy;
    endsequence

    property p_wel_set;
        i_cmd_valid && i_cmd == CMD_WREN && !o_busy |=> o_wel && o_cmd_taken;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("enable latch not set");
    property p_wel_clr;
        i_cmd_valid && i_cmd == CMD_WRDI && !o_busy |=> !o_wel;
    endproperty
    a_wel_clr: assert property (p_wel_clr) else $error("enable latch not cleared");
    property p_wrsr_ok;
        s_wrsr_ok |=> o_busy && !o_wel && o_op_start && o_cmd_taken;
    endproperty
    a_wrsr_ok: assert property (p_wrsr_ok) else $error("status write start wrong");
    property p_wrsr_locked;
        i_cmd_valid && i_cmd == CMD_WRSR && (o_srl || !o_wel)
            |=> o_cmd_ignored && $stable(o_bp) && $stable(o_tb) && $stable(o_drv);
    endproperty
    a_wrsr_locked: assert property (p_wrsr_locked) else $error("locked write took effect");
    property p_busy_ignore;
        o_busy && i_cmd_valid && !(i_cmd inside {CMD_NONE, CMD_RDSR, CMD_SUSPEND})
            |=> o_cmd_ignored && !o_cmd_taken && $stable(o_bp);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");
    property p_busy_clr;
        o_busy && i_op_done && !i_cmd_valid |=> !o_busy;
    endproperty
    a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared");
    property p_sus;
        i_cmd_valid && i_cmd == CMD_SUSPEND && o_busy |=> o_sus && !o_busy;
    endproperty
    a_sus: assert property (p_sus) else $error("suspend flag wrong");
    property p_lb_sticky;
        ($past(o_sec_lock) & ~o_sec_lock) == 3'h0;
    endproperty
    a_lb_sticky: assert property (p_lb_sticky) else $error("security lock cleared");
    property p_ads_hold;
        $changed(o_ads) |-> $past(i_cmd_valid)
            && $past(i_cmd) inside {CMD_EN4B, CMD_EX4B, CMD_SOFT_RST};
    endproperty
    a_ads_hold: assert property (p_ads_hold) else $error("address mode changed alone");
    property p_sdo_msb;
        s_rd_accept |-> o_sdo_active && o_sdo == o_rd_data[7];
    endproperty
    a_sdo_msb: assert property (p_sdo_msb) else $error("serial byte not msb first");
endmodule

bind serial_flash_status_regs serial_flash_status_props u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .i_op_done(i_op_done), .o_cmd_taken(o_cmd_taken), .o_cmd_ignored(o_cmd_ignored),
    .o_op_start(o_op_start), .o_rd_data(o_rd_data), .o_sdo(o_sdo),
    .o_sdo_active(o_sdo_active), .o_busy(o_busy), .o_wel(o_wel), .o_bp(o_bp),
    .o_tb(o_tb), .o_srl(o_srl), .o_sus(o_sus), .o_sec_lock(o_sec_lock),
    .o_ads(o_ads), .o_drv(o_drv)
);

// ---- verification/flash_host_model.sv ----
// Host controller model: decoded commands, serial reads, engine done pulse
module flash_host_model
    import flash_status_pkg::*;
(
    input  wire logic                         i_clk,       // System clock
    input  wire logic                         i_taken,     // Command accepted
    input  wire logic                         i_sdo,       // Serial status bit
    output logic                              o_cmd_valid, // Command strobe
    output flash_status_pkg::cmd_t            o_cmd,       // Command
    output flash_status_pkg::reg_sel_t        o_reg_sel,   // Byte select
    output logic [flash_status_pkg::BYTE_W-1:0] o_wr_data, // Write byte
    output logic                              o_op_done,   // Engine finished
    output logic                              o_shift      // Serial advance
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************
    // Driver tasks
    // ************
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = CMD_NONE;
        o_reg_sel = SEL_ONE;
        o_wr_data = 8'h00;
        o_op_done = 1'b0;
        o_shift = 1'b0;
    end
    task send(input cmd_t c, input reg_sel_t s, input logic [7:0] d,
              output logic tk);
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd = c;
        o_reg_sel = s;
        o_wr_data = d;
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd = CMD_NONE;
        // Flipped so stale data cannot pass
        o_wr_data = ~d;
        tk = i_taken;
    endtask
    // Engine done after n idle cycles
    task finish(input int n);
        repeat (n) @(posedge i_clk);
        #1;
        o_op_done = 1'b1;
        @(posedge i_clk);
        #1;
        o_op_done = 1'b0;
    endtask
    task read_serial(output logic [7:0] b);
        o_shift = 1'b1;
        repeat (8) begin
            b = {b[6:0], i_sdo};
            @(posedge i_clk);
            #1;
        end
        o_shift = 1'b0;
    endtask
endmodule

// ---- verification/test_serial_flash_status_regs.sv ----
// Self-checking testbench of the status register bank
module test_serial_flash_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_status_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid, op_done, shift, taken, ignored, op_start, preset, sdo, sdo_act;
    logic busy, write_enable_latch, tb, cmp, status_lock, paused_op_flag, active_address_width, boot_address_width, protect_scheme_select;
    cmd_t cmd;
    reg_sel_t sel;
    logic [7:0] wr_data, rd_data;
    logic [3:0] bp;
    logic [2:0] lb;
    logic [1:0] drv;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    flash_host_model host (.i_clk(clk), .i_taken(taken), .i_sdo(sdo), .o_cmd_valid(cmd_valid),
        .o_cmd(cmd), .o_reg_sel(sel), .o_wr_data(wr_data), .o_op_done(op_done), .o_shift(shift));
    serial_flash_status_regs dut (.i_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(cmd_valid),
        .i_cmd(cmd), .i_reg_sel(sel), .i_wr_data(wr_data), .i_op_done(op_done),
        .i_shift(shift), .o_cmd_taken(taken), .o_cmd_ignored(ignored), .o_op_start(op_start),
        .o_lock_preset(preset), .o_rd_data(rd_data), .o_sdo(sdo), .o_sdo_active(sdo_act),
        .o_busy(busy), .o_wel(write_enable_latch), .o_bp(bp), .o_tb(tb), .o_cmp(cmp), .o_srl(status_lock),
        .o_sus(paused_op_flag), .o_sec_lock(lb), .o_ads(active_address_width), .o_adp(boot_address_width), .o_wps(protect_scheme_select), .o_drv(drv));
    // ************
    // Shared tasks
    // ************
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task run(input cmd_t c, input reg_sel_t s, input logic [7:0] d, input logic tk);
        logic t;
        host.send(c, s, d, t);
        chk(8'(t), 8'(tk));
    endtask
    task rd(input reg_sel_t s, input logic [7:0] exp);
        logic [7:0] b;
        run(CMD_RDSR, s, 8'h00, 1'b1);
        chk(rd_data, exp);
        host.read_serial(b);
        chk(b, exp);
        chk(8'(sdo_act), 8'h00);
    endtask
    task do_reset();
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(8'(preset), 8'h01);
    endtask
    task end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ************
    // Scenarios
    // ************
    task t_defaults();
        rd(SEL_ONE, 8'h00);
        rd(SEL_TWO, 8'h00);
        rd(SEL_THREE, 8'h60);
    endtask
    task t_write_one();
        run(CMD_WRSR, SEL_ONE, 8'hFF, 1'b0);
        run(CMD_WREN, SEL_ONE, 8'h00, 1'b1);
        run(CMD_WRSR, SEL_ONE, 8'hFF, 1'b1);
        chk(8'({busy, write_enable_latch}), 8'h02);
        run(CMD_WREN, SEL_ONE, 8'h00, 1'b0);
        rd(SEL_ONE, 8'h7D);
        host.finish(3);
        chk(8'(busy), 8'h00);
        rd(SEL_ONE, 8'h7C);
        run(CMD_WREN, SEL_ONE, 8'h00, 1'b1);
        run(CMD_WRDI, SEL_ONE, 8'h00, 1'b1);
        chk(8'(write_enable_latch), 8'h00);
    endtask
    task automatic t_suspend();
        cmd_t ops[5] = '{CMD_PROG, CMD_QPROG, CMD_ERASE, CMD_SEC_PROG, CMD_SEC_ERASE};
        foreach (ops[i]) begin
            run(ops[i], SEL_ONE, 8'h00, 1'b0);
            run(CMD_WREN, SEL_ONE, 8'h00, 1'b1);
            run(ops[i], SEL_ONE, 8'h00, 1'b1);
            chk(8'({busy, write_enable_latch}), 8'h02);
            run(CMD_SUSPEND, SEL_ONE, 8'h00, 1'b1);
            chk(8'({paused_op_flag, busy}), 8'h02);
            run(CMD_RESUME, SEL_ONE, 8'h00, 1'b1);
            chk(8'({paused_op_flag, busy}), 8'h01);
            host.finish(0);
            chk(8'(busy), 8'h00);
        end
    endtask
    task t_addr();
        run(CMD_WREN, SEL_ONE, 8'h00, 1'b1);
        run(CMD_WRSR, SEL_THREE, 8'hBF, 1'b1);
        host.finish(1);
        rd(SEL_THREE, 8'h26);
        run(CMD_EN4B, SEL_ONE, 8'h00, 1'b1);
        chk(8'(active_address_width), 8'h01);
        run(CMD_EX4B, SEL_ONE, 8'h00, 1'b1);
        chk(8'(active_address_width), 8'h00);
        run(CMD_SOFT_RST, SEL_ONE, 8'h00, 1'b1);
        chk(8'(preset), 8'h01);
        chk(8'(active_address_width), 8'h01);
    endtask
    task t_lock();
        run(CMD_WREN, SEL_ONE, 8'h00, 1'b1);
        run(CMD_WRSR, SEL_TWO, 8'hEF, 1'b1);
        host.finish(2);
        rd(SEL_TWO, 8'h69);
        run(CMD_WREN, SEL_ONE, 8'h00, 1'b1);
        run(CMD_WRSR, SEL_ONE, 8'h00, 1'b0);
        chk(8'(bp), 8'h0F);
        do_reset();
        chk(8'(status_lock), 8'h00);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        do_reset();
        t_defaults();
        t_write_one();
        t_suspend();
        t_addr();
        t_lock();
        end_of_test();
    end
endmodule
